// >>> pkg/reader_timer_params.svh
`ifndef READER_TIMER_PARAMS_SVH
`define READER_TIMER_PARAMS_SVH

// ****************************************
// Register offsets
// ****************************************
`define AUX_STATUS_ADDR 6'h05
`define COMMAND_CTRL_ADDR 6'h09
`define LIVE_COUNT_ADDR 6'h0c
`define TICK_CONFIG_ADDR 6'h2a
`define TRIGGER_SEL_ADDR 6'h2b
`define RELOAD_COUNT_ADDR 6'h2c

// ****************************************
// Field positions
// ****************************************
`define COUNTING_FLAG_BIT 7
`define START_IMMEDIATELY_BIT 1
`define HALT_IMMEDIATELY_BIT 2
`define AUTO_RELOAD_BIT 5
`define DIV_EXP_MSB 4
`define START_FIRST_TX_BIT 0
`define START_LAST_TX_BIT 1
`define HALT_FIRST_RX_BIT 2
`define HALT_LAST_RX_BIT 3

// ****************************************
// Reset values
// ****************************************
`define TICK_CONFIG_RESET 8'h00
`define TRIGGER_SEL_RESET 8'h00
`define RELOAD_COUNT_RESET 8'h00
`define COUNT_RESET 8'h00

// ****************************************
// Timing
// ****************************************
`define CHIP_CLOCK_KHZ 13560
`define MAX_DIV_EXPONENT 21

`endif

// >>> pkg/reader_timer_pkg.sv
package reader_timer_pkg;

  // Register port address and data
  typedef logic [5:0] reg_addr_type;
  typedef logic [7:0] reg_byte_type;

  // Prescaler exponent field
  typedef logic [4:0] div_exp_type;

endpackage

// >>> hw/tick_divider.sv
`timescale 1ns/1ps

// Power-of-two prescaler; restart realigns the phase to a start event
module tick_divider #(
  parameter int DIV_W = 21
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Control
  input wire logic restart,
  input wire reader_timer_pkg::div_exp_type div_exp,
  // Timer clock enable
  output logic tick
);

  logic [DIV_W-1:0] cnt_q;
  logic [DIV_W-1:0] limit;
  logic [DIV_W:0] full;

  // Terminal count is two to the exponent, less one
  always_comb begin
    full = (DIV_W+1)'(1) << div_exp;
    limit = DIV_W'(full - (DIV_W+1)'(1));
  end

  // Counter restarts at zero so the first tick is a full period away
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q <= '0;
    end else if (restart || cnt_q >= limit) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + DIV_W'(1);
    end
  end

  assign tick = !restart && (cnt_q >= limit);

endmodule

// >>> hw/reader_event_timer.sv
`timescale 1ns/1ps
`include "reader_timer_params.svh"

// Function
// - Running nonzero counter decrements by one on each timer tick.
// - With auto reload, count of one reloads instead of reaching zero.
// - Start on enabled tx first bit, tx last bit, or software start.
// - Every start, even while running, loads the reload value.
// - Stop on enabled rx events, zero without reload, or software halt.
// - Reload or configuration writes leave the running count alone.
// - Software halt never raises the interrupt flag.
// - Timer tick is chip clock divided by two to the exponent.
// - Start sets counting flag, stop clears it; count moves only while set or on a start load.
// - Live count is readable while running.
// - Stop before zero halts without an interrupt.
// - Without a stop, count reaches zero and raises the interrupt.
// - Auto reload raises the interrupt once every period.
// - Timer events never influence transmit or receive.
// - Flag set on one to zero, or one to reload with auto reload.
module reader_event_timer #(
  parameter int DIV_W = 21
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Host register port
  input wire reader_timer_pkg::reg_addr_type reg_addr,
  input wire reader_timer_pkg::reg_byte_type reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output reader_timer_pkg::reg_byte_type reg_rdata,
  // Frame events from transmitter and receiver
  input wire logic tx_first_bit_event,
  input wire logic tx_last_bit_event,
  input wire logic rx_first_bit_event,
  input wire logic rx_last_bit_event,
  // Status towards interrupt system
  output logic countdown_irq_flag,
  output logic counting_flag,
  output logic [7:0] current_count
);

  // ****************************************
  // Configuration registers
  // ****************************************

  reader_timer_pkg::reg_byte_type tick_config_q;
  reader_timer_pkg::reg_byte_type trigger_select_q;
  reader_timer_pkg::reg_byte_type reload_count_q;
  reader_timer_pkg::reg_byte_type rdata_q;
  logic [7:0] count_q;
  logic [7:0] count_d;
  logic [7:0] reload_run_q;
  logic auto_run_q;
  reader_timer_pkg::div_exp_type exp_run_q;
  logic running_q;
  logic running_d;
  logic irq_q;
  logic irq_d;
  logic sw_start;
  logic sw_halt;
  logic start_ev;
  logic stop_ev;
  logic tick;
  logic [5:0] reg_sel;
  logic [3:0] frame_ev;
  logic [3:0] frame_hit;

  // ****************************************
  // Address decoding
  // ****************************************

  // Select positions, one per mapped register
  localparam int SEL_AUX = 0;
  localparam int SEL_CMD = 1;
  localparam int SEL_LIVE = 2;
  localparam int SEL_TICK = 3;
  localparam int SEL_TRIG = 4;
  localparam int SEL_RELOAD = 5;

  // Frame event sources, one per enable bit in trigger_select
  localparam int EVENT_COUNT = 4;

  // One-hot select shared by writes, reads and command strobes, so the three never disagree
  function automatic logic [5:0] reg_select(input reader_timer_pkg::reg_addr_type addr);
    logic [5:0] sel;
    sel = 6'h00;
    if (addr == `AUX_STATUS_ADDR) begin
      sel[SEL_AUX] = 1'b1;
    end else if (addr == `COMMAND_CTRL_ADDR) begin
      sel[SEL_CMD] = 1'b1;
    end else if (addr == `LIVE_COUNT_ADDR) begin
      sel[SEL_LIVE] = 1'b1;
    end else if (addr == `TICK_CONFIG_ADDR) begin
      sel[SEL_TICK] = 1'b1;
    end else if (addr == `TRIGGER_SEL_ADDR) begin
      sel[SEL_TRIG] = 1'b1;
    end else if (addr == `RELOAD_COUNT_ADDR) begin
      sel[SEL_RELOAD] = 1'b1;
    end
    return sel;
  endfunction

  // Unmapped addresses select nothing: writes drop, reads return zero
  assign reg_sel = reg_select(reg_addr);

  // ****************************************
  // Register access
  // ****************************************

  // Plain writes; command strobes are not stored and read back as zero
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tick_config_q <= `TICK_CONFIG_RESET;
      trigger_select_q <= `TRIGGER_SEL_RESET;
      reload_count_q <= `RELOAD_COUNT_RESET;
    end else if (reg_wr) begin
      if (reg_sel[SEL_TICK]) begin
        tick_config_q <= reg_wdata;
      end else if (reg_sel[SEL_TRIG]) begin
        trigger_select_q <= reg_wdata;
      end else if (reg_sel[SEL_RELOAD]) begin
        reload_count_q <= reg_wdata;
      end
    end
  end

  // Read data is registered, valid the cycle after the read strobe
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_q <= 8'h00;
    end else if (reg_rd) begin
      if (reg_sel[SEL_AUX]) begin
        rdata_q <= {running_q, 7'h00};
      end else if (reg_sel[SEL_LIVE]) begin
        rdata_q <= count_q;
      end else if (reg_sel[SEL_TICK]) begin
        rdata_q <= tick_config_q;
      end else if (reg_sel[SEL_TRIG]) begin
        rdata_q <= trigger_select_q;
      end else if (reg_sel[SEL_RELOAD]) begin
        rdata_q <= reload_count_q;
      end else begin
        rdata_q <= 8'h00;
      end
    end
  end

  // ****************************************
  // Start and stop events
  // ****************************************

  // Software strobes act in the cycle of the write
  assign sw_start = reg_wr && reg_sel[SEL_CMD] && reg_wdata[`START_IMMEDIATELY_BIT];
  assign sw_halt = reg_wr && reg_sel[SEL_CMD] && reg_wdata[`HALT_IMMEDIATELY_BIT];

  // Frame events packed in the bit order of their enables in trigger_select
  assign frame_ev[`START_FIRST_TX_BIT] = tx_first_bit_event;
  assign frame_ev[`START_LAST_TX_BIT] = tx_last_bit_event;
  assign frame_ev[`HALT_FIRST_RX_BIT] = rx_first_bit_event;
  assign frame_ev[`HALT_LAST_RX_BIT] = rx_last_bit_event;

  // An event whose enable is clear is ignored; the timer only listens to enabled frames and software strobes
  for (genvar i = 0; i < EVENT_COUNT; i++) begin : g_gate
    assign frame_hit[i] = frame_ev[i] && trigger_select_q[i];
  end

  // Any enabled start or stop source
  assign start_ev = sw_start
    || frame_hit[`START_FIRST_TX_BIT]
    || frame_hit[`START_LAST_TX_BIT];
  assign stop_ev = sw_halt
    || frame_hit[`HALT_FIRST_RX_BIT]
    || frame_hit[`HALT_LAST_RX_BIT];

  // ****************************************
  // Prescaler
  // ****************************************

  // Runs on the exponent latched at start, so a mid-run write cannot bend the period
  tick_divider #(
    .DIV_W(DIV_W)
  ) u_div (
    .clk(clk),
    .sys_rst(sys_rst),
    .restart(start_ev),
    .div_exp(exp_run_q),
    .tick(tick)
  );

  // ****************************************
  // Down counter
  // ****************************************

  // Start outranks stop; stop outranks a tick, so a halted count raises nothing
  always_comb begin
    count_d = count_q;
    running_d = running_q;
    irq_d = 1'b0;
    if (start_ev) begin
      count_d = reload_count_q;
      running_d = 1'b1;
    end else if (stop_ev) begin
      running_d = 1'b0;
    end else if (running_q && tick) begin
      if (count_q == 8'h01 && auto_run_q) begin
        count_d = reload_run_q;
        irq_d = 1'b1;
      end else if (count_q == 8'h01) begin
        count_d = 8'h00;
        running_d = 1'b0;
        irq_d = 1'b1;
      end else if (count_q == 8'h00) begin
        running_d = 1'b0;
      end else begin
        count_d = count_q - 8'h01;
      end
    end
  end

  // Count, run flag and interrupt flag; nothing here reaches the transmitter or receiver
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      count_q <= `COUNT_RESET;
      running_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      count_q <= count_d;
      running_q <= running_d;
      irq_q <= irq_d;
    end
  end

  // Working copy of the configuration, refreshed only at start
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reload_run_q <= `RELOAD_COUNT_RESET;
      auto_run_q <= 1'b0;
      exp_run_q <= '0;
    end else if (start_ev) begin
      reload_run_q <= reload_count_q;
      auto_run_q <= tick_config_q[`AUTO_RELOAD_BIT];
      exp_run_q <= tick_config_q[`DIV_EXP_MSB:0];
    end
  end

  // Outputs straight from flip-flops
  assign reg_rdata = rdata_q;
  assign countdown_irq_flag = irq_q;
  assign counting_flag = running_q;
  assign current_count = count_q;

  // ****************************************
  // Checks
  // ****************************************

  start_loads_a: assert property (@(posedge clk) disable iff (sys_rst)
    start_ev |=> (count_q == $past(reload_count_q)) && running_q)
    else $error("start did not load reload value");

  halt_stops_a: assert property (@(posedge clk) disable iff (sys_rst)
    (stop_ev && !start_ev) |=> !running_q)
    else $error("stop event left timer running");

  halt_silent_a: assert property (@(posedge clk) disable iff (sys_rst)
    (sw_halt && !start_ev) |=> !irq_q)
    else $error("software halt raised interrupt");

  step_down_a: assert property (@(posedge clk) disable iff (sys_rst)
    (running_q && tick && !start_ev && !stop_ev && count_q > 8'h01) |=> count_q == $past(count_q) - 8'h01)
    else $error("counter did not decrement");

  auto_reload_a: assert property (@(posedge clk) disable iff (sys_rst)
    (running_q && tick && !start_ev && !stop_ev && count_q == 8'h01 && auto_run_q)
    |=> (count_q == $past(reload_run_q)) && irq_q && running_q)
    else $error("auto reload failed");

  expire_irq_a: assert property (@(posedge clk) disable iff (sys_rst)
    (running_q && tick && !start_ev && !stop_ev && count_q == 8'h01 && !auto_run_q)
    |=> (count_q == 8'h00) && irq_q && !running_q)
    else $error("expiry did not flag and stop");

  idle_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
    (!running_q && !start_ev) |=> $stable(count_q))
    else $error("count moved while stopped");

  start_wins_a: assert property (@(posedge clk) disable iff (sys_rst)
    (start_ev && stop_ev) |=> running_q)
    else $error("stop beat coincident start");

  irq_cause_a: assert property (@(posedge clk) disable iff (sys_rst)
    irq_q |-> $past(running_q) && $past(count_q) == 8'h01)
    else $error("interrupt without count of one");

  no_early_tick_a: assert property (@(posedge clk) disable iff (sys_rst)
    (start_ev && tick_config_q[`DIV_EXP_MSB:0] != 5'h00) |=> !tick)
    else $error("tick right after start");

  // Register access, run-configuration latch, halt, tick spacing, run start, interrupt origin and auto reload
  latch_at_start_a: assert property (@(posedge clk) disable iff (sys_rst)
    !start_ev |=> $stable(reload_run_q) && $stable(auto_run_q) && $stable(exp_run_q))
    else $error("run configuration changed without a start");

  reload_write_a: assert property (@(posedge clk) disable iff (sys_rst)
    (reg_wr && reg_sel[SEL_RELOAD]) |=> reload_count_q == $past(reg_wdata))
    else $error("reload write did not land");

  halt_freezes_a: assert property (@(posedge clk) disable iff (sys_rst)
    (stop_ev && !start_ev) |=> $stable(count_q) && !irq_q)
    else $error("stop moved the count or raised interrupt");

  live_read_a: assert property (@(posedge clk) disable iff (sys_rst)
    (reg_rd && reg_sel[SEL_LIVE]) |=> reg_rdata == $past(count_q))
    else $error("live count read mismatch");

  status_read_a: assert property (@(posedge clk) disable iff (sys_rst)
    (reg_rd && reg_sel[SEL_AUX]) |=> reg_rdata == {$past(running_q), 7'h00})
    else $error("status read mismatch");

  tick_gap_a: assert property (@(posedge clk) disable iff (sys_rst)
    (tick && !start_ev && exp_run_q != 5'h00) |=> !tick)
    else $error("divided tick on two cycles in a row");

  irq_from_tick_a: assert property (@(posedge clk) disable iff (sys_rst)
    irq_q |-> $past(tick) && !$past(start_ev) && !$past(stop_ev))
    else $error("interrupt without a clean tick");

  run_rise_a: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(running_q) |-> $past(start_ev))
    else $error("timer started without a start event");

  auto_keeps_a: assert property (@(posedge clk) disable iff (sys_rst)
    (running_q && auto_run_q && count_q != 8'h00 && !stop_ev) |=> running_q)
    else $error("auto reload timer stopped by itself");

  irq_reload_a: assert property (@(posedge clk) disable iff (sys_rst)
    (irq_q && auto_run_q) |-> running_q && count_q == reload_run_q)
    else $error("periodic interrupt without reload");

endmodule

// >>> tb/cpu.sv
`timescale 1ns/1ps
`include "reader_timer_params.svh"

// ****
// Host software and frame events
// ****
module cpu (
  // Clock
  input wire logic clk,
  // Register port
  output reader_timer_pkg::reg_addr_type reg_addr,
  output reader_timer_pkg::reg_byte_type reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire reader_timer_pkg::reg_byte_type reg_rdata,
  // Frame events, rx last down to tx first
  output logic [3:0] frame_ev
);
  // Idle bus at time zero
  initial begin
    reg_addr = 6'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    frame_ev = 4'h0;
  end

  // Released data is inverted so a stale byte is never taken for a fresh one
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(negedge clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
  endtask

  // Registered answer is settled one edge after the strobe
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(negedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(negedge clk);
    reg_rd <= 1'b0;
    d = reg_rdata;
  endtask

  // Software never programs an exponent above the top value
  task automatic set_tick(input logic auto_on, input logic [4:0] e);
    wr(`TICK_CONFIG_ADDR, {2'b00, auto_on, (e > 5'd21) ? 5'd21 : e});
  endtask

  // One-cycle frame event pulse
  task automatic pulse(input logic [3:0] m);
    @(negedge clk);
    frame_ev <= m;
    @(negedge clk);
    frame_ev <= 4'h0;
  endtask
endmodule

// >>> tb/tb_top.sv
`timescale 1ns/1ps
`include "reader_timer_params.svh"

module tb_top;
  // ****
  // Wiring
  // ****
  logic clk;
  logic sys_rst;
  reader_timer_pkg::reg_addr_type reg_addr;
  reader_timer_pkg::reg_byte_type reg_wdata;
  reader_timer_pkg::reg_byte_type reg_rdata;
  logic reg_wr;
  logic reg_rd;
  logic [3:0] frame_ev;
  logic countdown_irq_flag;
  logic counting_flag;
  logic [7:0] current_count;
  int miscompares;
  int cmp_count;

  // 100 MHz clock
  always #5 clk = ~clk;

  reader_event_timer #(.DIV_W(21)) reader_event_timer_inst (
    .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .tx_first_bit_event(frame_ev[0]), .tx_last_bit_event(frame_ev[1]),
    .rx_first_bit_event(frame_ev[2]), .rx_last_bit_event(frame_ev[3]),
    .countdown_irq_flag(countdown_irq_flag), .counting_flag(counting_flag),
    .current_count(current_count));

  cpu cpu_inst (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .frame_ev(frame_ev));

  // ****
  // Checking helpers
  // ****
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic stop_test();
    if (miscompares == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Bounded wait for the interrupt pulse; n counts falling edges waited
  task automatic wait_irq(input int lim, output int n);
    for (n = 1; n <= lim; n++) begin
      @(negedge clk);
      if (countdown_irq_flag === 1'b1) return;
    end
    chk(8'h00, 8'h01);
    stop_test();
  endtask

  // ****
  // Scenarios
  // ****
  task automatic regs_test();
    logic [7:0] d;
    logic [5:0] adr [7] = '{`AUX_STATUS_ADDR, `COMMAND_CTRL_ADDR, `LIVE_COUNT_ADDR,
      `TICK_CONFIG_ADDR, `TRIGGER_SEL_ADDR, `RELOAD_COUNT_ADDR, 6'h3f};
    foreach (adr[i]) begin
      cpu_inst.rd(adr[i], d);
      chk(d, 8'h00);
    end
    cpu_inst.wr(`TRIGGER_SEL_ADDR, 8'h0f);
    cpu_inst.wr(`LIVE_COUNT_ADDR, 8'h55);
    cpu_inst.wr(6'h3f, 8'h55);
    cpu_inst.rd(`TRIGGER_SEL_ADDR, d);
    chk(d, 8'h0f);
    cpu_inst.rd(`LIVE_COUNT_ADDR, d);
    chk(d, 8'h00);
    cpu_inst.wr(`TRIGGER_SEL_ADDR, 8'h00);
  endtask

  task automatic oneshot_test();
    int n;
    cpu_inst.set_tick(1'b0, 5'd2);
    cpu_inst.wr(`RELOAD_COUNT_ADDR, 8'h03);
    cpu_inst.wr(`COMMAND_CTRL_ADDR, 8'h02);
    chk(current_count, 8'h03);
    chk({7'h00, counting_flag}, 8'h01);
    repeat (2) @(negedge clk);
    chk(current_count, 8'h03);
    wait_irq(40, n);
    chk(8'(n), 8'h0a);
    chk(current_count, 8'h00);
    chk({7'h00, counting_flag}, 8'h00);
    @(negedge clk);
    chk({7'h00, countdown_irq_flag}, 8'h00);
  endtask

  task automatic halt_test();
    logic [7:0] d;
    logic [7:0] held;
    logic seen;
    cpu_inst.set_tick(1'b0, 5'd1);
    cpu_inst.wr(`RELOAD_COUNT_ADDR, 8'hc8);
    cpu_inst.wr(`COMMAND_CTRL_ADDR, 8'h02);
    cpu_inst.rd(`AUX_STATUS_ADDR, d);
    chk(d, 8'h80);
    cpu_inst.wr(`RELOAD_COUNT_ADDR, 8'h05);
    cpu_inst.rd(`LIVE_COUNT_ADDR, d);
    chk(8'((d < 8'hc8) && (d > 8'hc0)), 8'h01);
    cpu_inst.wr(`COMMAND_CTRL_ADDR, 8'h04);
    held = current_count;
    chk({7'h00, counting_flag}, 8'h00);
    seen = 1'b0;
    repeat (30) begin
      @(negedge clk);
      seen |= countdown_irq_flag;
    end
    chk({7'h00, seen}, 8'h00);
    chk(current_count, held);
    cpu_inst.wr(`COMMAND_CTRL_ADDR, 8'h02);
    chk(current_count, 8'h05);
    cpu_inst.wr(`COMMAND_CTRL_ADDR, 8'h04);
  endtask

  task automatic event_test();
    logic [3:0] go [2] = '{4'h1, 4'h2};
    logic [3:0] halt [2] = '{4'h4, 4'h8};
    cpu_inst.set_tick(1'b0, 5'd3);
    cpu_inst.wr(`RELOAD_COUNT_ADDR, 8'h32);
    cpu_inst.wr(`TRIGGER_SEL_ADDR, 8'h0f);
    foreach (go[i]) begin
      cpu_inst.pulse(go[i]);
      chk({7'h00, counting_flag}, 8'h01);
      repeat (20) @(negedge clk);
      chk(current_count, 8'h30);
      cpu_inst.pulse(halt[i]);
      chk({7'h00, counting_flag}, 8'h00);
    end
    cpu_inst.pulse(4'h9);
    chk(current_count, 8'h32);
    chk({7'h00, counting_flag}, 8'h01);
    repeat (20) @(negedge clk);
    cpu_inst.pulse(4'h1);
    chk(current_count, 8'h32);
    cpu_inst.wr(`TRIGGER_SEL_ADDR, 8'h00);
    cpu_inst.pulse(4'h4);
    chk({7'h00, counting_flag}, 8'h01);
    cpu_inst.wr(`COMMAND_CTRL_ADDR, 8'h04);
    cpu_inst.pulse(4'h1);
    chk({7'h00, counting_flag}, 8'h00);
  endtask

  task automatic auto_test();
    int n;
    for (int e = 0; e < 2; e++) begin
      cpu_inst.set_tick(1'b1, 5'(e));
      cpu_inst.wr(`RELOAD_COUNT_ADDR, 8'h03);
      cpu_inst.wr(`COMMAND_CTRL_ADDR, 8'h02);
      wait_irq(20, n);
      repeat (3) begin
        wait_irq(20, n);
        chk(8'(n), 8'(3 << e));
        chk(current_count, 8'h03);
      end
    end
    cpu_inst.wr(`COMMAND_CTRL_ADDR, 8'h04);
    chk({7'h00, counting_flag}, 8'h00);
  endtask

  // Reset for 16 cycles, then every scenario in turn
  initial begin
    clk = 1'b0;
    sys_rst = 1'b1;
    miscompares = 0;
    cmp_count = 0;
    repeat (16) @(posedge clk);
    @(negedge clk);
    sys_rst = 1'b0;
    regs_test();
    oneshot_test();
    halt_test();
    event_test();
    auto_test();
    stop_test();
  end
endmodule
